// >>> tb/flm_host_model.sv
// Behavioural management-bus host on the command port
module flm_host_model (
	input  wire logic        clk_i,
	input  wire logic        busy_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] rdata_i,
	output logic             req_o,
	output logic [2:0]       cmd_o,
	output logic [31:0]      arg_o
);
	// ****************************************
	// One command outstanding, answer awaited
	// ****************************************
	initial begin
		req_o = 1'b0;
		cmd_o = 3'h0;
		arg_o = 32'h0000_0000;
	end
	// Clock values stay raw counts; the host converts units
	task automatic xfer(input logic [2:0] c, input logic [31:0] a, output logic [31:0] d,
		output bit ok);
		int n;
		ok = 0;
		d = 32'h0000_0000;
		@(posedge clk_i);
		req_o <= 1'b1;
		cmd_o <= c;
		arg_o <= a;
		@(posedge clk_i);
		req_o <= 1'b0;
		for (n = 0; n < 60 && !ok; n++) begin
			@(posedge clk_i);
			if (ack_i === 1'b1) begin
				ok = 1;
				d = rdata_i;
			end
		end
	endtask
endmodule

// >>> tb/flm_monitor.sv
// Port-level assertions for the fault log and start-up manager
module flm_monitor #(
	parameter int unsigned INIT_CYC = 50
) (
	input wire logic        REF_CLK_I,
	input wire logic        RSTN_I,
	input wire logic        HOST_CLK_I,
	input wire logic        HOST_BUSY_O,
	input wire logic        HOST_ACK_O,
	input wire logic        EXT_RSTN_I,
	input wire logic        FAULT_VALID_I,
	input wire logic        FAULT_READY_O,
	input wire logic        NVM_WR_O,
	input wire logic        NVM_READY_I,
	input wire logic [11:0] NVM_ADDR_O,
	input wire logic [63:0] NVM_DATA_O,
	input wire logic        LOG_CHK_VALID_I,
	input wire logic        LOG_CHK_OK_I,
	input wire logic        LOG_MARK_VALID_O,
	input wire logic        LOG_MARK_OK_O,
	input wire logic        LOG_DROP_O,
	input wire logic [6:0]  BUS_ADDR_O,
	input wire logic        BUS_ALERT_OUT_O,
	input wire logic        CFG_BAD_FLAG_O,
	input wire logic        IO_HIZ_O,
	input wire logic        RUNNING_O
);
	// ****************************************
	// Run-length counters and assertions
	// ****************************************
	int unsigned hiz_n;
	int unsigned ext_n;
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			hiz_n <= 0;
			ext_n <= 0;
		end else begin
			hiz_n <= IO_HIZ_O ? hiz_n + 1 : 0;
			ext_n <= EXT_RSTN_I ? 0 : ext_n + 1;
		end
	end
	a_addr_held: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		RUNNING_O |-> $stable(BUS_ADDR_O)) else $error("address moved");
	a_init_len: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		$rose(RUNNING_O) |-> !IO_HIZ_O && hiz_n >= INIT_CYC) else $error("init too short");
	a_ext_hold: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		ext_n > 30 |-> !RUNNING_O && IO_HIZ_O) else $error("reset ignored");
	a_ready_run: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		FAULT_READY_O |-> RUNNING_O) else $error("ready off-run");
	a_rec_write: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		FAULT_VALID_I && FAULT_READY_O |=> !FAULT_READY_O ##[0:60]
		(NVM_WR_O && NVM_ADDR_O < 12'h064)) else $error("no record");
	a_wr_hold: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		NVM_WR_O && !NVM_READY_I && EXT_RSTN_I |=> NVM_WR_O && $stable(NVM_ADDR_O)
		&& $stable(NVM_DATA_O)) else $error("write changed");
	a_log_mark: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		LOG_MARK_VALID_O || LOG_DROP_O |-> LOG_MARK_VALID_O && $past(LOG_CHK_VALID_I) &&
		LOG_MARK_OK_O == $past(LOG_CHK_OK_I) && LOG_DROP_O == !LOG_MARK_OK_O)
		else $error("mark wrong");
	a_alert_stick: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		BUS_ALERT_OUT_O || CFG_BAD_FLAG_O |=> BUS_ALERT_OUT_O && CFG_BAD_FLAG_O)
		else $error("alert dropped");
	a_ack_bound: assert property (@(posedge HOST_CLK_I) disable iff (!RSTN_I)
		$rose(HOST_BUSY_O) |-> ##[1:50] (HOST_ACK_O && !HOST_BUSY_O))
		else $error("no answer");
	cover property (@(posedge REF_CLK_I) $rose(RUNNING_O));
	cover property (@(posedge REF_CLK_I) LOG_DROP_O);
	cover property (@(posedge REF_CLK_I) NVM_WR_O && NVM_ADDR_O == flm_pkg::A_SNAP);
	cover property (@(posedge HOST_CLK_I) HOST_ACK_O);
endmodule

bind flm_top flm_monitor #(.INIT_CYC(INIT_CYC)) u_mon (.*);

// >>> tb/tb_top.sv
// Randomised self-checking bench of the fault log and start-up manager
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************
	// Stimulus, capture and checks
	// ****************************************
	logic REF_CLK_I = 0, HOST_CLK_I = 0, RSTN_I = 0, EXT_RSTN_I = 1, BROWNOUT_I = 0, CE_I = 1;
	logic ADDR_STRAP_MSB_I = 0, ADDR_STRAP_MID_I = 0, ADDR_STRAP_LSB_I = 0, WDT_KICK_I = 1;
	logic FAULT_VALID_I = 0, MEAS_VALID_I = 0, FW_SUM_OK_I = 1, CFG_SUM_OK_I = 1;
	logic CFG_IN_RANGE_I = 1, LOG_CHK_VALID_I = 0, LOG_CHK_OK_I = 0, NVM_READY_I = 0;
	logic HOST_REQ_I, HOST_BUSY_O, HOST_ACK_O, FAULT_READY_O, NVM_WR_O, LOG_MARK_VALID_O;
	logic LOG_MARK_OK_O, LOG_DROP_O, BUS_ALERT_OUT_O, CFG_BAD_FLAG_O, CFG_CLEAR_O, IO_HIZ_O;
	logic RUNNING_O, SYNC_PULSE_O;
	logic [1:0] FAULT_RAIL_I = 0, MEAS_RAIL_I = 0, r;
	logic [2:0] HOST_CMD_I, FAULT_TYPE_I = 0, t;
	logic [11:0] FAULT_VOLT_I = 0, MEAS_VALUE_I = 0, NVM_ADDR_O, v, wq[$];
	logic [15:0] IO_PIN_I = 0;
	logic [31:0] HOST_ARG_I, HOST_RDATA_O, NVM_RTC_I = 0, NVM_RSTCNT_I = 0, d;
	logic [63:0] NVM_DATA_O, dq[$];
	logic [6:0] BUS_ADDR_O, atab[8] = '{7'h11, 7'h13, 7'h17, 7'h31, 7'h33, 7'h71, 7'h73, 7'h77};
	int fail_count = 0, tests_run = 0, n;
	always #50 REF_CLK_I = ~REF_CLK_I;
	always #7.5 HOST_CLK_I = ~HOST_CLK_I;
	always @(negedge REF_CLK_I) begin
		NVM_READY_I <= 1'($urandom);
		IO_PIN_I <= 16'($urandom);
		LOG_CHK_VALID_I <= !RUNNING_O && ($urandom % 4 == 0);
		LOG_CHK_OK_I <= 1'($urandom);
	end
	always @(posedge REF_CLK_I) if (NVM_WR_O && NVM_READY_I) begin
		wq.push_back(NVM_ADDR_O);
		dq.push_back(NVM_DATA_O);
	end
	flm_top #(.NRAIL(4), .INIT_CYC(50), .MS_CYC(10), .PEAK_MS(5)) DUT (.*);
	flm_host_model u_host (.clk_i(HOST_CLK_I), .busy_i(HOST_BUSY_O), .ack_i(HOST_ACK_O),
		.rdata_i(HOST_RDATA_O), .req_o(HOST_REQ_I), .cmd_o(HOST_CMD_I), .arg_o(HOST_ARG_I));
	task automatic chk(input string s, input logic [63:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", s, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic hang(input string s);
		chk(s, 0, 1);
		stop_test();
	endtask
	task automatic wait_run;
		for (n = 0; n < 1000 && RUNNING_O !== 1'b1; n++) @(negedge REF_CLK_I);
		if (RUNNING_O !== 1'b1) hang("start-up end");
	endtask
	task automatic host(input logic [2:0] c, input logic [31:0] a);
		bit ok;
		u_host.xfer(c, a, d, ok);
		if (!ok) hang("host answer");
		@(negedge REF_CLK_I);
	endtask
	function automatic int snaps;
		snaps = 0;
		foreach (wq[i]) snaps += int'(wq[i] >= flm_pkg::A_SNAP);
	endfunction
	initial begin
		void'($urandom(30));
		for (int k = 0; k < 8; k++) begin
			RSTN_I = 0;
			{ADDR_STRAP_MSB_I, ADDR_STRAP_MID_I, ADDR_STRAP_LSB_I} = 3'(k);
			CFG_SUM_OK_I = k != 5;
			NVM_RSTCNT_I = $urandom % 1000;
			repeat (16) @(negedge REF_CLK_I);
			RSTN_I = 1;
			wait_run();
			{ADDR_STRAP_MSB_I, ADDR_STRAP_MID_I, ADDR_STRAP_LSB_I} = ~3'(k);
			repeat (5) @(negedge REF_CLK_I);
			chk("bus address", BUS_ADDR_O, atab[k]);
			chk("config bad", {BUS_ALERT_OUT_O, CFG_BAD_FLAG_O}, {2{k == 5}});
			host(flm_pkg::CMD_RD_RESETS, 0);
			chk("reset count", d, NVM_RSTCNT_I + 1);
			$display("power-up test %0d done", k);
		end
		wq.delete();
		dq.delete();
		v = 12'($urandom % 1023 + 1);
		MEAS_RAIL_I = 2'h2;
		MEAS_VALID_I = 1;
		for (int i = 0; i < 3; i++) begin
			MEAS_VALUE_I = i == 1 ? v + 12'h400 : v;
			@(negedge REF_CLK_I);
		end
		MEAS_VALID_I = 0;
		repeat (200) @(negedge REF_CLK_I);
		chk("peak writes", wq.size(), 1);
		chk("peak", {wq[0], dq[0][11:0]}, {flm_pkg::A_PEAK + 12'h002, v + 12'h400});
		$display("peak test done");
		for (int f = 0; f < 3; f++) begin
			if (f == 2) host(flm_pkg::CMD_CLR_SNAP, 0);
			wq.delete();
			dq.delete();
			{r, t, v} = 17'($urandom);
			for (n = 0; n < 100 && FAULT_READY_O !== 1'b1; n++) @(negedge REF_CLK_I);
			if (FAULT_READY_O !== 1'b1) hang("fault ready");
			{FAULT_VALID_I, FAULT_RAIL_I, FAULT_TYPE_I, FAULT_VOLT_I} = {1'b1, r, t, v};
			@(negedge REF_CLK_I);
			FAULT_VALID_I = 0;
			repeat (150) @(negedge REF_CLK_I);
			chk("record leads", wq[0] < 12'h064, 1);
			chk("record fields", {dq[0][48:44], dq[0][11:0]}, {r, t, v});
			chk("snapshot words", snaps(), f == 1 ? 0 : 5);
			host(flm_pkg::CMD_RD_STATUS, 32'(r));
			chk("rail status", d[t], 1);
			$display("fault test %0d done", f);
		end
		wq.delete();
		BROWNOUT_I = 1;
		repeat (10) @(negedge REF_CLK_I);
		chk("ready in brownout", FAULT_READY_O, 0);
		chk("clock saved", wq.size() > 0 && wq[0] == flm_pkg::A_RTC, 1);
		BROWNOUT_I = 0;
		host(flm_pkg::CMD_SET_RTC, 32'h0001_0000);
		host(flm_pkg::CMD_RD_RTC, 0);
		chk("clock set", d - 32'h0001_0000 < 32'h0000_0064, 1);
		host(flm_pkg::CMD_CLR_RESETS, 0);
		host(flm_pkg::CMD_RD_RESETS, 0);
		chk("count cleared", d, 0);
		EXT_RSTN_I = 0;
		repeat (40) @(negedge REF_CLK_I);
		chk("held in reset", {RUNNING_O, IO_HIZ_O}, 2'b01);
		EXT_RSTN_I = 1;
		wait_run();
		chk("address kept", BUS_ADDR_O, atab[7]);
		host(flm_pkg::CMD_RD_RESETS, 0);
		chk("count after reset", d, 1);
		$display("reset test done");
		stop_test();
	end
endmodule

// >>> verilog/flm_pkg.sv
// Shared constants and types of the fault log and start-up manager
package flm_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned REF_HZ      = 10_000_000;
	localparam int unsigned MS_CYC      = REF_HZ / 1000;
	localparam int unsigned T_INIT_MS   = 40;
	localparam int unsigned INIT_CYC    = MS_CYC * T_INIT_MS;
	localparam int unsigned T_PEAK_S    = 30;
	localparam int unsigned PEAK_MS     = T_PEAK_S * 1000;
	localparam int unsigned T_SYNC_MS   = 250;
	localparam int unsigned T_WDT_MS    = 1000;
	// Minimum reset pulse: least time, rounded up
	localparam int unsigned T_EXTRST_NS = 2000;
	localparam int unsigned EXTRST_CYC  = (T_EXTRST_NS * (REF_HZ / 1_000_000) + 999) / 1000;
	// Internal release time: longest time, rounded down
	localparam int unsigned RESET_RELEASE_TIME_NS    = 10_000;
	localparam int unsigned IRT_CYC     = RESET_RELEASE_TIME_NS * (REF_HZ / 1_000_000) / 1000;

	// ****************************************************************
	// Non-volatile memory map
	// ****************************************************************
	localparam int unsigned NVM_AW    = 12;
	localparam int unsigned NVM_DW    = 64;
	localparam int unsigned LOG_DEPTH = 100;
	localparam logic [NVM_AW-1:0] A_LOG    = 12'h000;
	localparam logic [NVM_AW-1:0] A_PEAK   = 12'h100;
	localparam logic [NVM_AW-1:0] A_RSTCNT = 12'h180;
	localparam logic [NVM_AW-1:0] A_RTC    = 12'h181;
	localparam logic [NVM_AW-1:0] A_SNAP   = 12'h200;

	// ****************************************************************
	// Address straps, MSB pin first
	// ****************************************************************
	localparam logic [6:0] ADDR_LLL = 7'h11;
	localparam logic [6:0] ADDR_LLH = 7'h13;
	localparam logic [6:0] ADDR_LHL = 7'h17;
	localparam logic [6:0] ADDR_LHH = 7'h31;
	localparam logic [6:0] ADDR_HLL = 7'h33;
	localparam logic [6:0] ADDR_HLH = 7'h71;
	localparam logic [6:0] ADDR_HHL = 7'h73;
	localparam logic [6:0] ADDR_HHH = 7'h77;

	// ****************************************************************
	// Host commands and core states
	// ****************************************************************
	typedef enum logic [2:0] {
		CMD_RD_STATUS  = 3'h0,
		CMD_CLR_STATUS = 3'h1,
		CMD_RD_RESETS  = 3'h2,
		CMD_CLR_RESETS = 3'h3,
		CMD_RD_RTC     = 3'h4,
		CMD_SET_RTC    = 3'h5,
		CMD_CLR_SNAP   = 3'h6,
		CMD_RD_FLAGS   = 3'h7
	} flm_cmd_e;

	typedef enum logic [1:0] {
		ST_RST  = 2'h0,
		ST_INIT = 2'h1,
		ST_RUN  = 2'h2
	} flm_state_e;

endpackage

// >>> verilog/flm_top.sv
// Fault logging, reset and initialization manager with host command port
module flm_top #(
	parameter int unsigned NRAIL    = 24,
	parameter int unsigned IO_W     = 16,
	parameter int unsigned VW       = 12,
	parameter int unsigned INIT_CYC = flm_pkg::INIT_CYC,
	parameter int unsigned MS_CYC   = flm_pkg::MS_CYC,
	parameter int unsigned PEAK_MS  = flm_pkg::PEAK_MS
) (
	input  wire logic                       REF_CLK_I,
	input  wire logic                       RSTN_I,
	input  wire logic                       CE_I,
	input  wire logic                       HOST_CLK_I,
	input  wire logic                       HOST_REQ_I,
	input  wire logic [2:0]                 HOST_CMD_I,
	input  wire logic [31:0]                HOST_ARG_I,
	output logic                            HOST_BUSY_O,
	output logic                            HOST_ACK_O,
	output logic [31:0]                     HOST_RDATA_O,
	input  wire logic                       EXT_RSTN_I,
	input  wire logic                       ADDR_STRAP_MSB_I,
	input  wire logic                       ADDR_STRAP_MID_I,
	input  wire logic                       ADDR_STRAP_LSB_I,
	input  wire logic                       BROWNOUT_I,
	input  wire logic [IO_W-1:0]            IO_PIN_I,
	input  wire logic                       FAULT_VALID_I,
	output logic                            FAULT_READY_O,
	input  wire logic [$clog2(NRAIL)-1:0]   FAULT_RAIL_I,
	input  wire logic [2:0]                 FAULT_TYPE_I,
	input  wire logic [VW-1:0]              FAULT_VOLT_I,
	input  wire logic                       MEAS_VALID_I,
	input  wire logic [$clog2(NRAIL)-1:0]   MEAS_RAIL_I,
	input  wire logic [VW-1:0]              MEAS_VALUE_I,
	input  wire logic                       WDT_KICK_I,
	input  wire logic                       FW_SUM_OK_I,
	input  wire logic                       CFG_SUM_OK_I,
	input  wire logic                       CFG_IN_RANGE_I,
	input  wire logic                       LOG_CHK_VALID_I,
	input  wire logic                       LOG_CHK_OK_I,
	input  wire logic [31:0]                NVM_RTC_I,
	input  wire logic [31:0]                NVM_RSTCNT_I,
	output logic                            NVM_WR_O,
	input  wire logic                       NVM_READY_I,
	output logic [flm_pkg::NVM_AW-1:0]      NVM_ADDR_O,
	output logic [flm_pkg::NVM_DW-1:0]      NVM_DATA_O,
	output logic                            LOG_MARK_VALID_O,
	output logic                            LOG_MARK_OK_O,
	output logic                            LOG_DROP_O,
	output logic [6:0]                      BUS_ADDR_O,
	output logic                            BUS_ALERT_OUT_O,
	output logic                            CFG_BAD_FLAG_O,
	output logic                            CFG_CLEAR_O,
	output logic                            IO_HIZ_O,
	output logic                            RUNNING_O,
	output logic                            SYNC_PULSE_O
);
	localparam int unsigned RW = $clog2(NRAIL);
	localparam int unsigned AW = flm_pkg::NVM_AW;
	localparam int unsigned DW = flm_pkg::NVM_DW;

	// ****************************************************************
	// Host clock domain: toggle handshake toward the core
	// ****************************************************************
	logic        req_tgl_h_r;
	logic [2:0]  cmd_h_r;
	logic [31:0] arg_h_r;
	logic        ack_s1_h_r;
	logic        ack_s2_h_r;
	logic        ack_seen_h_r;
	logic        ack_tgl_r;
	logic [31:0] rdata_r;

	assign HOST_BUSY_O = req_tgl_h_r ^ ack_seen_h_r;

	always_ff @(posedge HOST_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			req_tgl_h_r  <= 1'b0;
			cmd_h_r      <= 3'h0;
			arg_h_r      <= 32'h0000_0000;
			ack_s1_h_r   <= 1'b0;
			ack_s2_h_r   <= 1'b0;
			ack_seen_h_r <= 1'b0;
			HOST_ACK_O   <= 1'b0;
			HOST_RDATA_O <= 32'h0000_0000;
		end else begin
			ack_s1_h_r <= ack_tgl_r;
			ack_s2_h_r <= ack_s1_h_r;
			HOST_ACK_O <= 1'b0;
			if (HOST_REQ_I && !HOST_BUSY_O) begin
				req_tgl_h_r <= ~req_tgl_h_r;
				cmd_h_r     <= HOST_CMD_I;
				arg_h_r     <= HOST_ARG_I;
			end
			// Result settles before the ack toggle lands
			if (ack_s2_h_r != ack_seen_h_r) begin
				ack_seen_h_r <= ack_s2_h_r;
				HOST_ACK_O   <= 1'b1;
				HOST_RDATA_O <= rdata_r;
			end
		end
	end

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [IO_W+6:0] sy1_r;
	logic [IO_W+6:0] sy2_r;

	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			// Only the reset pin idles high; no false request or brownout edge
			sy1_r <= (IO_W+7)'(1) << (IO_W+5);
			sy2_r <= (IO_W+7)'(1) << (IO_W+5);
		end else begin
			sy1_r <= {req_tgl_h_r, EXT_RSTN_I, ADDR_STRAP_MSB_I, ADDR_STRAP_MID_I,
				ADDR_STRAP_LSB_I, BROWNOUT_I, 1'b1, IO_PIN_I};
			sy2_r <= sy1_r;
		end
	end

	wire            req_sync  = sy2_r[IO_W+6];
	wire            extrst_n  = sy2_r[IO_W+5];
	wire [2:0]      strap     = sy2_r[IO_W+4:IO_W+2];
	wire            brownout  = sy2_r[IO_W+1];
	wire [IO_W-1:0] io_sync   = sy2_r[IO_W-1:0];

	// ****************************************************************
	// Core state
	// ****************************************************************
	flm_pkg::flm_state_e state_r;
	logic [31:0] cnt_r;
	logic [31:0] ms_cnt_r;
	logic [15:0] ms_evt_r;
	logic [31:0] ext_cnt_r;
	logic        pwr_up_r;
	logic        fw_fail_r;
	logic        wdt_cause_r;
	logic [31:0] wdt_ms_r;
	logic        sync_r;
	logic        cfg_bad_r;
	logic        req_seen_r;
	logic        bo_prev_r;
	logic [31:0] rtc_r;
	logic [31:0] since_r;
	logic [31:0] rstcnt_r;
	logic        snap_taken_r;
	logic        rec_pend_r;

	wire ms_tick   = (ms_cnt_r == MS_CYC - 1);
	wire running   = (state_r == flm_pkg::ST_RUN);
	wire init_end  = (state_r == flm_pkg::ST_INIT) && (cnt_r == INIT_CYC - 1);
	wire ext_rst   = (ext_cnt_r == flm_pkg::EXTRST_CYC);
	wire wdt_to    = running && ms_tick && (wdt_ms_r == flm_pkg::T_WDT_MS - 1);
	wire fw_bad    = init_end && !FW_SUM_OK_I;
	wire new_req   = req_sync ^ req_seen_r;
	wire fault_acc = FAULT_VALID_I && FAULT_READY_O;
	wire [2:0] cmd = cmd_h_r;

	// Only pre-brownout faults drain
	assign FAULT_READY_O = running && !brownout && !rec_pend_r;

	wire clr_snap  = new_req && (cmd == flm_pkg::CMD_CLR_SNAP);
	wire snap_go   = fault_acc && (!snap_taken_r || clr_snap);

	assign IO_HIZ_O  = !running;
	assign RUNNING_O = running;

	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_r <= flm_pkg::ST_RST;
			cnt_r   <= 32'h0000_0000;
		end else if (CE_I) begin
			unique case (state_r)
				flm_pkg::ST_RST: begin
					cnt_r <= extrst_n ? cnt_r + 32'h0000_0001 : 32'h0000_0000;
					if (extrst_n && cnt_r == flm_pkg::IRT_CYC - 1) begin
						state_r <= flm_pkg::ST_INIT;
						cnt_r   <= 32'h0000_0000;
					end
				end
				flm_pkg::ST_INIT: begin
					cnt_r <= cnt_r + 32'h0000_0001;
					if (init_end) begin
						state_r <= fw_bad ? flm_pkg::ST_RST : flm_pkg::ST_RUN;
						cnt_r   <= 32'h0000_0000;
					end
				end
				flm_pkg::ST_RUN: begin
					cnt_r <= 32'h0000_0000;
				end
			endcase
			if (ext_rst || wdt_to) begin
				state_r <= flm_pkg::ST_RST;
				cnt_r   <= 32'h0000_0000;
			end
		end
	end

	// ****************************************************************
	// Timebase, reset sources and sync-pin pulses
	// ****************************************************************
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ms_cnt_r    <= 32'h0000_0000;
			ms_evt_r    <= 16'h0000;
			ext_cnt_r   <= 32'h0000_0000;
			wdt_ms_r    <= 32'h0000_0000;
			wdt_cause_r <= 1'b0;
			fw_fail_r   <= 1'b0;
			sync_r      <= 1'b0;
		end else if (CE_I) begin
			ms_cnt_r  <= ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
			ext_cnt_r <= extrst_n ? 32'h0000_0000 :
				(ext_rst ? ext_cnt_r : ext_cnt_r + 32'h0000_0001);
			if (!running || WDT_KICK_I)
				wdt_ms_r <= 32'h0000_0000;
			else if (ms_tick)
				wdt_ms_r <= wdt_ms_r + 32'h0000_0001;
			if (wdt_to)
				wdt_cause_r <= 1'b1;
			else if (init_end)
				wdt_cause_r <= 1'b0;
			if (fw_bad)
				fw_fail_r <= 1'b1;
			else if (init_end)
				fw_fail_r <= 1'b0;
			// 250 ms sync pulses while firmware fails
			if (!fw_fail_r) begin
				sync_r   <= 1'b0;
				ms_evt_r <= 16'h0000;
			end else if (ms_tick) begin
				ms_evt_r <= ms_evt_r + 16'h0001;
				if (ms_evt_r == 16'(flm_pkg::T_SYNC_MS - 1)) begin
					ms_evt_r <= 16'h0000;
					sync_r   <= ~sync_r;
				end
			end
		end
	end

	assign SYNC_PULSE_O = sync_r;

	// ****************************************************************
	// Power-up checks, straps, clocks and counters
	// ****************************************************************
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			pwr_up_r         <= 1'b1;
			BUS_ADDR_O       <= flm_pkg::ADDR_LLL;
			cfg_bad_r        <= 1'b0;
			CFG_CLEAR_O      <= 1'b0;
			LOG_MARK_VALID_O <= 1'b0;
			LOG_MARK_OK_O    <= 1'b0;
			LOG_DROP_O       <= 1'b0;
			bo_prev_r        <= 1'b0;
			rtc_r            <= 32'h0000_0000;
			since_r          <= 32'h0000_0000;
			rstcnt_r         <= 32'h0000_0000;
		end else if (CE_I) begin
			CFG_CLEAR_O <= 1'b0;
			bo_prev_r   <= brownout;
			// Sampled once per power up
			if (pwr_up_r && state_r == flm_pkg::ST_RST) begin
				unique case (strap)
					3'h0: BUS_ADDR_O <= flm_pkg::ADDR_LLL;
					3'h1: BUS_ADDR_O <= flm_pkg::ADDR_LLH;
					3'h2: BUS_ADDR_O <= flm_pkg::ADDR_LHL;
					3'h3: BUS_ADDR_O <= flm_pkg::ADDR_LHH;
					3'h4: BUS_ADDR_O <= flm_pkg::ADDR_HLL;
					3'h5: BUS_ADDR_O <= flm_pkg::ADDR_HLH;
					3'h6: BUS_ADDR_O <= flm_pkg::ADDR_HHL;
					3'h7: BUS_ADDR_O <= flm_pkg::ADDR_HHH;
				endcase
			end
			LOG_MARK_VALID_O <= pwr_up_r && state_r == flm_pkg::ST_INIT && LOG_CHK_VALID_I;
			LOG_MARK_OK_O    <= LOG_CHK_OK_I;
			LOG_DROP_O       <= pwr_up_r && state_r == flm_pkg::ST_INIT &&
				LOG_CHK_VALID_I && !LOG_CHK_OK_I;
			if (state_r != flm_pkg::ST_RUN)
				since_r <= 32'h0000_0000;
			else if (ms_tick)
				since_r <= since_r + 32'h0000_0001;
			if (new_req && cmd == flm_pkg::CMD_SET_RTC)
				rtc_r <= arg_h_r;
			else if (running && ms_tick)
				rtc_r <= rtc_r + 32'h0000_0001;
			if (new_req && cmd == flm_pkg::CMD_CLR_RESETS)
				rstcnt_r <= 32'h0000_0000;
			if (init_end && FW_SUM_OK_I) begin
				rstcnt_r <= (pwr_up_r ? NVM_RSTCNT_I : rstcnt_r) + 32'h0000_0001;
				if (pwr_up_r) begin
					rtc_r    <= NVM_RTC_I;
					pwr_up_r <= 1'b0;
					if (!CFG_SUM_OK_I) begin
						cfg_bad_r   <= 1'b1;
						CFG_CLEAR_O <= 1'b1;
					end
				end
				if (wdt_cause_r && !CFG_IN_RANGE_I)
					CFG_CLEAR_O <= 1'b1;
			end
		end
	end

	assign BUS_ALERT_OUT_O = cfg_bad_r;
	assign CFG_BAD_FLAG_O  = cfg_bad_r;

	// ****************************************************************
	// Per-rail status, snapshot copy and peak windows
	// ****************************************************************
	logic [7:0]    stat_r  [NRAIL];
	logic [7:0]    snap_r  [NRAIL];
	logic [VW-1:0] peak_r  [NRAIL];
	logic [VW-1:0] wmax_r  [NRAIL];
	logic [15:0]   wms_r   [NRAIL];
	logic [NRAIL-1:0] wact_r;
	logic [NRAIL-1:0] ppend_r;
	logic [NRAIL-1:0] pgnt;
	logic [IO_W-1:0]  snap_io_r;

	genvar gi;
	generate
		for (gi = 0; gi < NRAIL; gi++) begin : g_rail
			wire fhit = fault_acc && FAULT_RAIL_I == RW'(gi);
			wire chit = new_req && cmd == flm_pkg::CMD_CLR_STATUS && arg_h_r[RW-1:0] == RW'(gi);
			wire mhit = running && MEAS_VALID_I && MEAS_RAIL_I == RW'(gi);
			wire wend = wact_r[gi] && ms_tick && wms_r[gi] == 16'(PEAK_MS - 1);
			wire [7:0] set_m = fhit ? 8'h01 << FAULT_TYPE_I : 8'h00;
			// A fault in the clearing cycle still sets its bit
			wire [7:0] stat_nxt = (chit ? 8'h00 : stat_r[gi]) | set_m;
			always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
				if (!RSTN_I) begin
					stat_r[gi]  <= 8'h00;
					snap_r[gi]  <= 8'h00;
					peak_r[gi]  <= '0;
					wmax_r[gi]  <= '0;
					wms_r[gi]   <= 16'h0000;
					wact_r[gi]  <= 1'b0;
					ppend_r[gi] <= 1'b0;
				end else if (CE_I) begin
					stat_r[gi] <= stat_nxt;
					if (snap_go)
						snap_r[gi] <= stat_nxt;
					if (!wact_r[gi] && mhit && MEAS_VALUE_I > peak_r[gi]) begin
						wact_r[gi] <= 1'b1;
						wmax_r[gi] <= MEAS_VALUE_I;
						wms_r[gi]  <= 16'h0000;
					end else if (wact_r[gi]) begin
						if (mhit && MEAS_VALUE_I > wmax_r[gi])
							wmax_r[gi] <= MEAS_VALUE_I;
						if (ms_tick)
							wms_r[gi] <= wms_r[gi] + 16'h0001;
						if (wend) begin
							wact_r[gi] <= 1'b0;
							peak_r[gi] <= (mhit && MEAS_VALUE_I > wmax_r[gi]) ?
								MEAS_VALUE_I : wmax_r[gi];
							ppend_r[gi] <= 1'b1;
						end
					end
					if (pgnt[gi] && !wend)
						ppend_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Single non-volatile writer
	// ****************************************************************
	logic [DW-1:0] rec_r;
	logic          snap_act_r;
	logic [RW:0]   snap_idx_r;
	logic          rc_pend_r;
	logic          rtc_pend_r;
	logic [AW-1:0] log_ptr_r;
	logic [RW-1:0] peak_sel;

	always_comb begin
		peak_sel = '0;
		for (int i = NRAIL - 1; i >= 0; i--) begin
			if (ppend_r[i])
				peak_sel = RW'(i);
		end
	end

	// Fixed priority: a fault record always goes ahead of the snapshot
	wire idle    = !NVM_WR_O || NVM_READY_I;
	wire g_rec   = idle && rec_pend_r;
	wire g_snap  = idle && !rec_pend_r && snap_act_r;
	wire g_rc    = idle && !rec_pend_r && !snap_act_r && rc_pend_r;
	wire g_rtc   = idle && !rec_pend_r && !snap_act_r && !rc_pend_r && rtc_pend_r;
	wire g_peak  = idle && !rec_pend_r && !snap_act_r && !rc_pend_r && !rtc_pend_r &&
		(|ppend_r);
	wire snap_last = (snap_idx_r == (RW+1)'(NRAIL));
	wire [7:0] snap_word = snap_last ? 8'h00 : snap_r[snap_idx_r[RW-1:0]];

	assign pgnt = g_peak ? (NRAIL)'(1) << peak_sel : '0;

	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rec_pend_r   <= 1'b0;
			rec_r        <= '0;
			snap_act_r   <= 1'b0;
			snap_idx_r   <= '0;
			snap_io_r    <= '0;
			snap_taken_r <= 1'b0;
			rc_pend_r    <= 1'b0;
			rtc_pend_r   <= 1'b0;
			log_ptr_r    <= flm_pkg::A_LOG;
			NVM_WR_O     <= 1'b0;
			NVM_ADDR_O   <= '0;
			NVM_DATA_O   <= '0;
		end else if (CE_I) begin
			if (NVM_WR_O && NVM_READY_I)
				NVM_WR_O <= 1'b0;
			if (g_rec) begin
				rec_pend_r <= 1'b0;
				NVM_WR_O   <= 1'b1;
				NVM_ADDR_O <= log_ptr_r;
				NVM_DATA_O <= rec_r;
				log_ptr_r  <= (log_ptr_r == AW'(flm_pkg::LOG_DEPTH - 1)) ?
					flm_pkg::A_LOG : log_ptr_r + AW'(1);
			end else if (g_snap) begin
				NVM_WR_O   <= 1'b1;
				NVM_ADDR_O <= flm_pkg::A_SNAP + AW'(snap_idx_r);
				NVM_DATA_O <= snap_last ? DW'(snap_io_r) : DW'(snap_word);
				snap_idx_r <= snap_idx_r + (RW+1)'(1);
				if (snap_last)
					snap_act_r <= 1'b0;
			end else if (g_rc) begin
				rc_pend_r  <= 1'b0;
				NVM_WR_O   <= 1'b1;
				NVM_ADDR_O <= flm_pkg::A_RSTCNT;
				NVM_DATA_O <= DW'(rstcnt_r);
			end else if (g_rtc) begin
				rtc_pend_r <= 1'b0;
				NVM_WR_O   <= 1'b1;
				NVM_ADDR_O <= flm_pkg::A_RTC;
				NVM_DATA_O <= DW'(rtc_r);
			end else if (g_peak) begin
				NVM_WR_O   <= 1'b1;
				NVM_ADDR_O <= flm_pkg::A_PEAK + AW'(peak_sel);
				NVM_DATA_O <= DW'(peak_r[peak_sel]);
			end
			if (fault_acc) begin
				rec_pend_r <= 1'b1;
				rec_r <= DW'({FAULT_RAIL_I, FAULT_TYPE_I, since_r, FAULT_VOLT_I});
			end
			// Snapshot stays untouched until the host clears it
			if (snap_go) begin
				snap_taken_r <= 1'b1;
				snap_act_r   <= 1'b1;
				snap_idx_r   <= '0;
				snap_io_r    <= io_sync;
			end else if (clr_snap) begin
				snap_taken_r <= 1'b0;
			end
			if ((init_end && FW_SUM_OK_I) || (new_req && cmd == flm_pkg::CMD_CLR_RESETS))
				rc_pend_r <= 1'b1;
			if (brownout && !bo_prev_r)
				rtc_pend_r <= 1'b1;
		end
	end

	// ****************************************************************
	// Host command execution
	// ****************************************************************
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			req_seen_r <= 1'b0;
			ack_tgl_r  <= 1'b0;
			rdata_r    <= 32'h0000_0000;
		end else if (CE_I) begin
			if (new_req) begin
				req_seen_r <= req_sync;
				ack_tgl_r  <= ~ack_tgl_r;
				unique case (cmd)
					flm_pkg::CMD_RD_STATUS:  rdata_r <= 32'(stat_r[arg_h_r[RW-1:0]]);
					flm_pkg::CMD_RD_RESETS:  rdata_r <= rstcnt_r;
					flm_pkg::CMD_RD_RTC:     rdata_r <= rtc_r;
					flm_pkg::CMD_RD_FLAGS:   rdata_r <= {27'h000_0000, fw_fail_r,
						wdt_cause_r, snap_taken_r, brownout, cfg_bad_r};
					default:                 rdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule
